// ---- rtl/i2cf_params.svh ----
`ifndef I2CF_PARAMS_SVH
`define I2CF_PARAMS_SVH
// Contract
// - filter both lines: 00 off, 01/10/11 reject 1/2/4 tick spikes
// - writing 1 to force stop drives a stop condition; bit resets to 0
// - own address low, bits 6:0, reset 0x55, is the 7-bit address
// - 10-bit mode puts extension bits 9:7 above the low address field
// - after stretch release wait setup value minus one i2c ticks

// register byte offsets
`define I2CF_OFS_CTRL    8'h00
`define I2CF_OFS_SCTRL   8'h04
`define I2CF_OFS_STAT    8'h08
// control register fields
`define I2CF_MODE10_BIT  0
`define I2CF_FILT_LSB    13
`define I2CF_FSTOP_BIT   15
// slave control register fields
`define I2CF_SA_LSB      0
`define I2CF_EXT_LSB     7
`define I2CF_SETUP_LSB   16
// reset values
`define I2CF_SA_RST      7'h55
`define I2CF_SETUP_RST   16'h000F
// ten-bit header prefix of the first address byte
`define I2CF_HDR10       5'h1E
// system clocks per i2c functional clock tick (250 MHz / 16)
`define I2CF_I2C_DIV     16
`endif

// ---- rtl/i2cf_pkg.sv ----
package i2cf_pkg;
  typedef struct packed {
    logic       force_stop;
    logic [1:0] filt_sel;
    logic       mode10;
  } i2cf_ctrl_t;

  typedef struct packed {
    logic [15:0] setup;
    logic [2:0]  ext;
    logic [6:0]  addr;
  } i2cf_scfg_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } i2cf_lines_t;

  typedef enum logic [2:0] {
    SLV_IDLE, SLV_ADDR1, SLV_ADDR2, SLV_ACK, SLV_STRETCH, SLV_SETUP
  } i2cf_slv_st_t;

  typedef enum logic [2:0] {
    STP_IDLE, STP_SCL_LOW, STP_SDA_LOW, STP_SCL_REL, STP_SDA_REL
  } i2cf_stop_st_t;
endpackage

// ---- rtl/i2cf_spike_filter.sv ----
`timescale 1ns/10ps
`default_nettype none
module i2cf_spike_filter (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       tick_i,
  input  wire logic [1:0] sel_i,
  input  wire logic       raw_i,
  output logic            filt_o
);
  import i2cf_pkg::*;

  logic [2:0] cnt_q, cnt_d;
  logic       filt_q, filt_d;
  logic [2:0] lim;

  // a change is accepted once it has outlasted the spike width in ticks
  always_comb begin
    unique case (sel_i)
      2'b00: lim = 3'h0;
      2'b01: lim = 3'h1;
      2'b10: lim = 3'h2;
      2'b11: lim = 3'h4;
    endcase
    cnt_d  = cnt_q;
    filt_d = filt_q;
    if (sel_i == 2'b00) begin
      filt_d = raw_i; // no filter inserted
      cnt_d  = 3'h0;
    end else if (raw_i == filt_q) begin
      cnt_d = 3'h0;
    end else if (tick_i) begin
      if (cnt_q >= lim) begin
        filt_d = raw_i;
        cnt_d  = 3'h0;
      end else begin
        cnt_d = cnt_q + 3'h1;
      end
    end
  end

  // idle bus level is high
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_q  <= 3'h0;
      filt_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_d;
      filt_q <= filt_d;
    end
  end

  assign filt_o = filt_q;
endmodule // i2cf_spike_filter
`default_nettype wire

// ---- rtl/i2cf_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "i2cf_params.svh"
module i2cf_top #(
  parameter int unsigned I2C_DIV = `I2CF_I2C_DIV
) (
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [7:0]         paddr_i,
  input  wire logic [31:0]        pwdata_i,
  output logic [31:0]             prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  input  wire logic               scl_i,
  output logic                    scl_o,
  output logic                    scl_oe_o,
  input  wire logic               sda_i,
  output logic                    sda_o,
  output logic                    sda_oe_o,
  input  wire logic               engine_ready_i,
  output i2cf_pkg::i2cf_lines_t   lines_filt_o,
  output logic                    addr_match_o,
  output logic                    data_go_o
);
  import i2cf_pkg::*;

  i2cf_ctrl_t    ctrl_q, ctrl_d;
  i2cf_scfg_t    scfg_q, scfg_d;
  logic [31:0]   prdata_q, prdata_d;
  logic          pready_q, pready_d, pslverr_q, pslverr_d;
  logic          fs_start;
  logic [7:0]    div_q, div_d;
  logic          tick;
  i2cf_lines_t   sync1_q, sync2_q, filt, prev_q;
  logic          scl_rise, scl_fall, start_det, stop_det;
  i2cf_slv_st_t  slv_q, slv_d;
  logic [7:0]    shift_q, shift_d;
  logic [3:0]    bits_q, bits_d;
  logic          hdr_q, hdr_d;
  logic [15:0]   setup_q, setup_d;
  logic          match_q, match_d, go_q, go_d;
  i2cf_stop_st_t stp_q, stp_d;
  logic          scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;

  // apb decode: answer one cycle after setup, unmapped gives pslverr
  always_comb begin
    ctrl_d    = ctrl_q;
    scfg_d    = scfg_q;
    fs_start  = 1'b0;
    pready_d  = psel_i & ~penable_i;
    pslverr_d = 1'b0;
    prdata_d  = 32'h0000_0000;
    if (psel_i && !penable_i && !pwrite_i) begin
      unique case (paddr_i)
        `I2CF_OFS_CTRL: begin
          prdata_d[`I2CF_MODE10_BIT] = ctrl_q.mode10;
          prdata_d[`I2CF_FILT_LSB+:2] = ctrl_q.filt_sel;
          prdata_d[`I2CF_FSTOP_BIT] = ctrl_q.force_stop;
        end
        `I2CF_OFS_SCTRL: begin
          prdata_d[`I2CF_SA_LSB+:7] = scfg_q.addr;
          prdata_d[`I2CF_EXT_LSB+:3] = scfg_q.ext;
          prdata_d[`I2CF_SETUP_LSB+:16] = scfg_q.setup;
        end
        `I2CF_OFS_STAT: begin
          prdata_d[0] = filt.sda;
          prdata_d[1] = filt.scl;
          prdata_d[2] = (stp_q != STP_IDLE);
          prdata_d[3] = (slv_q != SLV_IDLE);
          prdata_d[4] = (slv_q == SLV_STRETCH);
        end
        default: pslverr_d = 1'b1;
      endcase
    end else if (psel_i && !penable_i) begin
      if (paddr_i != `I2CF_OFS_CTRL && paddr_i != `I2CF_OFS_SCTRL &&
          paddr_i != `I2CF_OFS_STAT) begin
        pslverr_d = 1'b1;
      end
    end
    // writes land at the completing access edge
    if (psel_i && penable_i && pready_q && pwrite_i) begin
      if (paddr_i == `I2CF_OFS_CTRL) begin
        ctrl_d.mode10 = pwdata_i[`I2CF_MODE10_BIT];
        ctrl_d.filt_sel = pwdata_i[`I2CF_FILT_LSB+:2];
        ctrl_d.force_stop = pwdata_i[`I2CF_FSTOP_BIT];
        fs_start = pwdata_i[`I2CF_FSTOP_BIT] & (stp_q == STP_IDLE);
      end else if (paddr_i == `I2CF_OFS_SCTRL) begin
        scfg_d.addr = pwdata_i[`I2CF_SA_LSB+:7];
        scfg_d.ext = pwdata_i[`I2CF_EXT_LSB+:3];
        scfg_d.setup = pwdata_i[`I2CF_SETUP_LSB+:16];
      end
    end
  end

  // register file and bus answer flops
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_q    <= '0; // force stop resets to 0
      scfg_q    <= {`I2CF_SETUP_RST, 3'h0, `I2CF_SA_RST};
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      scfg_q    <= scfg_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // i2c functional clock tick divider
  always_comb begin
    tick  = (div_q == 8'(I2C_DIV - 1));
    div_d = tick ? 8'h00 : div_q + 8'h01;
  end

  // pin synchronisers and edge history
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div_q   <= 8'h00;
      sync1_q <= '1;
      sync2_q <= '1;
      prev_q  <= '1;
    end else begin
      div_q   <= div_d;
      sync1_q <= {scl_i, sda_i};
      sync2_q <= sync1_q;
      prev_q  <= filt;
    end
  end

  // one spike filter per bus line
  for (genvar g = 0; g < 2; g++) begin : g_filt
    i2cf_spike_filter u_filt (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .tick_i  (tick),
      .sel_i   (ctrl_q.filt_sel),
      .raw_i   (sync2_q[g]),
      .filt_o  (filt[g])
    );
  end

  // bus events seen on the filtered lines
  assign scl_rise  = filt.scl & ~prev_q.scl;
  assign scl_fall  = ~filt.scl & prev_q.scl;
  assign start_det = filt.scl & prev_q.scl & ~filt.sda & prev_q.sda;
  assign stop_det  = filt.scl & prev_q.scl & filt.sda & ~prev_q.sda;

  // slave address match, ack, stretch and data setup
  always_comb begin
    slv_d   = slv_q;
    shift_d = shift_q;
    bits_d  = bits_q;
    hdr_d   = hdr_q;
    setup_d = setup_q;
    match_d = 1'b0;
    go_d    = 1'b0;
    if (stop_det || stp_q != STP_IDLE) begin
      slv_d = SLV_IDLE;
    end else if (start_det) begin
      slv_d  = SLV_ADDR1;
      bits_d = 4'h0;
      hdr_d  = 1'b0;
    end else begin
      unique case (slv_q)
        SLV_IDLE: ;
        SLV_ADDR1, SLV_ADDR2: begin
          if (scl_rise && bits_q < 4'h8) begin
            shift_d = {shift_q[6:0], filt.sda};
            bits_d  = bits_q + 4'h1;
          end else if (scl_fall && bits_q == 4'h8) begin
            slv_d = SLV_IDLE;
            if (slv_q == SLV_ADDR2) begin
              if (shift_q == {scfg_q.ext[0], scfg_q.addr}) begin
                slv_d = SLV_ACK;
              end
            end else if (!ctrl_q.mode10) begin
              if (shift_q[7:1] == scfg_q.addr) begin
                slv_d = SLV_ACK;
              end
            end else if (shift_q[7:3] == `I2CF_HDR10 &&
                         shift_q[2:1] == scfg_q.ext[2:1]) begin
              slv_d = SLV_ACK;
            end
          end
        end
        SLV_ACK: begin
          if (scl_fall) begin
            bits_d = 4'h0;
            if (ctrl_q.mode10 && !hdr_q) begin
              hdr_d = 1'b1;
              slv_d = SLV_ADDR2;
            end else begin
              slv_d   = SLV_STRETCH;
              match_d = 1'b1;
            end
          end
        end
        SLV_STRETCH: begin
          if (engine_ready_i) begin
            slv_d = SLV_SETUP;
            setup_d = (scfg_q.setup == 16'h0000) ? 16'h0000
                                                 : scfg_q.setup - 16'h0001;
          end
        end
        SLV_SETUP: begin
          if (tick) begin
            if (setup_q <= 16'h0001) begin
              slv_d = SLV_IDLE;
              go_d  = 1'b1; // setup elapsed, data may be driven
            end else begin
              setup_d = setup_q - 16'h0001;
            end
          end
        end
      endcase
    end
  end

  // force stop: scl low, sda low, release scl, then release sda
  always_comb begin
    stp_d = stp_q;
    unique case (stp_q)
      STP_IDLE:    if (fs_start) stp_d = STP_SCL_LOW;
      STP_SCL_LOW: if (tick) stp_d = STP_SDA_LOW;
      STP_SDA_LOW: if (tick) stp_d = STP_SCL_REL;
      STP_SCL_REL: if (tick && filt.scl) stp_d = STP_SDA_REL;
      STP_SDA_REL: if (tick) stp_d = STP_IDLE; // sda rises with scl high
    endcase
    scl_oe_d = (stp_d == STP_SCL_LOW) || (stp_d == STP_SDA_LOW) ||
               (slv_d == SLV_STRETCH);
    sda_oe_d = (stp_d == STP_SDA_LOW) || (stp_d == STP_SCL_REL) ||
               (slv_d == SLV_ACK);
  end

  // bus side state flops
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      slv_q    <= SLV_IDLE;
      shift_q  <= 8'h00;
      bits_q   <= 4'h0;
      hdr_q    <= 1'b0;
      setup_q  <= 16'h0000;
      match_q  <= 1'b0;
      go_q     <= 1'b0;
      stp_q    <= STP_IDLE;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      slv_q    <= slv_d;
      shift_q  <= shift_d;
      bits_q   <= bits_d;
      hdr_q    <= hdr_d;
      setup_q  <= setup_d;
      match_q  <= match_d;
      go_q     <= go_d;
      stp_q    <= stp_d;
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
    end
  end

  // outputs, open drain pads only ever pull low
  assign prdata_o     = prdata_q;
  assign pready_o     = pready_q;
  assign pslverr_o    = pslverr_q;
  assign scl_o        = 1'b0;
  assign sda_o        = 1'b0;
  assign scl_oe_o     = scl_oe_q;
  assign sda_oe_o     = sda_oe_q;
  assign lines_filt_o = filt;
  assign addr_match_o = match_q;
  assign data_go_o    = go_q;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_filter_off_follow: assert property (
    (ctrl_q.filt_sel == 2'b00) |=> (filt == $past(sync2_q)))
    else $error("unfiltered line does not follow pin");
  a_filter_tick_only: assert property (
    (ctrl_q.filt_sel != 2'b00 && !tick) |=> $stable(filt))
    else $error("filtered line moved between ticks");
  a_stop_launch: assert property (
    fs_start |=> (stp_q == STP_SCL_LOW) ##1 scl_oe_o)
    else $error("force stop did not start");
  a_stop_sda_last: assert property (
    (stp_q == STP_SDA_REL) |-> (!scl_oe_o && !sda_oe_o))
    else $error("stop releases lines out of order");
  a_ack_own7: assert property (
    (slv_q == SLV_ADDR1 && scl_fall && bits_q == 4'h8 && !ctrl_q.mode10 &&
     !stop_det && !start_det && stp_q == STP_IDLE)
    |=> ((slv_q == SLV_ACK) == ($past(shift_q[7:1]) == $past(scfg_q.addr))))
    else $error("7-bit address match wrong");
  a_ack_own10: assert property (
    (slv_q == SLV_ADDR2 && scl_fall && bits_q == 4'h8 &&
     !stop_det && !start_det && stp_q == STP_IDLE)
    |=> ((slv_q == SLV_ACK) ==
         ($past(shift_q) == $past({scfg_q.ext[0], scfg_q.addr}))))
    else $error("10-bit address match wrong");
  a_setup_load: assert property (
    (slv_q == SLV_STRETCH && engine_ready_i && scfg_q.setup > 16'h0001 &&
     !stop_det && !start_det && stp_q == STP_IDLE)
    |=> (setup_q == $past(scfg_q.setup) - 16'h0001) && !scl_oe_o)
    else $error("setup count not loaded");
  a_setup_go: assert property (
    data_go_o |-> ($past(slv_q) == SLV_SETUP && $past(tick)))
    else $error("data released early");

  c_match7: cover property (addr_match_o && !ctrl_q.mode10);
  c_match10: cover property (addr_match_o && ctrl_q.mode10);
  c_force_stop: cover property (
    (stp_q == STP_SDA_REL) ##1 (stp_q == STP_IDLE));
  c_data_go: cover property (data_go_o);
endmodule // i2cf_top
`default_nettype wire

// ---- verification/i2c_filter_slave_address_config_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module i2c_filter_slave_address_config_bench;
  import i2cf_pkg::*;
  localparam int D = 2;
  typedef struct {logic [7:0] a; logic [31:0] w, r; logic e;} i2cf_row_t;
  typedef struct {logic [31:0] c, s; logic [7:0] b1, b2;
                  logic ten, hit; int su;} i2cf_acase_t;
  logic        clk_i, rst_n_i, psel, pen, pwr, rdy_e, er, m_scl, m_sda;
  logic        pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, fault;
  logic        match, go, matched, go_seen, ack, m, prev, stp, both, clr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          miscompares, comparisons, gocnt, n;
  i2cf_lines_t filt;
  wire logic   scl_w;
  wire logic   sda_w;
  i2cf_row_t   rows [6] = '{'{8'h00, 32'h0000_6001, 32'h0000_6001, 1'b0},
    '{8'h08, 32'hFFFF_FFFF, 32'h0000_0003, 1'b0},
    '{8'h04, 32'h0005_03AA, 32'h0005_03AA, 1'b0},
    '{8'h0C, 32'h0000_1234, 32'h0000_0000, 1'b1},
    '{8'h00, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{8'h04, 32'h000F_0055, 32'h000F_0055, 1'b0}};
  i2cf_acase_t ac [4] = '{'{0, 32'h0005_0055, 8'hAA, 8'h00, 0, 1, 5},
    '{0, 32'h0005_0054, 8'hAA, 8'h00, 0, 0, 5},
    '{1, 32'h0003_02AA, 8'hF4, 8'hAA, 1, 1, 3},
    '{1, 32'h0003_022A, 8'hF4, 8'hAA, 1, 0, 3}};
  int          fs [7][3] = '{'{0, 1, 0}, '{1, D, 1}, '{1, 2*D, 0},
    '{2, 2*D, 1}, '{2, 3*D, 0}, '{3, 4*D, 1}, '{3, 5*D, 0}};
  // open-drain wires with pull-ups
  assign scl_w = ~((scl_oe & ~scl_o) | m_scl);
  assign sda_w = ~((sda_oe & ~sda_o) | m_sda);
  i2cf_top #(.I2C_DIV(D)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .engine_ready_i(rdy_e), .lines_filt_o(filt), .addr_match_o(match),
    .data_go_o(go));
  i2cf_bus_master #(.HB(8*D)) master (.clk_i(clk_i), .scl_i(scl_w),
    .sda_i(sda_w), .scl_lo_o(m_scl), .sda_lo_o(m_sda), .fault_o(fault));
  // clock and global watchdog
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    repeat (90000) @(posedge clk_i);
    miscompares++;
    report_and_stop();
  end
  // sticky pulse catchers and setup-wait counter
  always @(posedge clk_i) begin
    if (clr || !rst_n_i) begin
      matched <= 1'b0;
      go_seen <= 1'b0;
      gocnt   <= 0;
    end else begin
      if (match === 1'b1) matched <= 1'b1;
      if (go === 1'b1) go_seen <= 1'b1;
      if (rdy_e && !go_seen) gocnt <= gocnt + 1;
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // one apb transfer; answer taken at the edge where pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d; pen <= 1'b0;
    @(posedge clk_i) pen <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_i);
      if (pready === 1'b1) break;
    end
    if (k == 50) begin
      miscompares++;
      report_and_stop();
    end
    rd = prdata; er = pslverr;
    psel <= 1'b0; pen <= 1'b0;
  endtask
  task automatic do_reset();
    @(posedge clk_i) rst_n_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
  endtask
  initial begin
    rst_n_i = 0; psel = 0; pen = 0; pwr = 0; paddr = 0; pwdata = 0;
    rdy_e = 0; clr = 0;
    miscompares = 0; comparisons = 0;
    do_reset();
    chk("lines", filt, 2'b11);
    // register rows: write, then read back
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].w);
      chk("werr", er, rows[i].e);
      apb(1'b0, rows[i].a, 0);
      chk("rdata", rd, rows[i].r);
      chk("rerr", er, rows[i].e);
    end
    $display("test registers done");
    // spike widths just rejected and just passed per enabled filter setting, one passed spike with the filter off
    foreach (fs[i]) begin
      apb(1'b1, 8'h00, fs[i][0] << 13);
      repeat (20) @(posedge clk_i);
      m = 1'b1;
      fork
        master.spike(fs[i][1]);
        repeat (fs[i][1] + 20*D) @(posedge clk_i) m &= filt.sda;
      join
      chk("filt", m, fs[i][2]);
    end
    apb(1'b1, 8'h00, 0);
    $display("test filter done");
    // own address match in 7 and 10 bit modes, then setup wait
    foreach (ac[i]) begin
      apb(1'b1, 8'h00, ac[i].c);
      apb(1'b1, 8'h04, ac[i].s);
      clr <= 1'b1;
      @(posedge clk_i) clr <= 1'b0;
      master.start();
      master.xbyte(ac[i].b1, ack);
      if (ac[i].ten) master.xbyte(ac[i].b2, ack);
      chk("ack", ack, ac[i].hit);
      repeat (8) @(posedge clk_i);
      chk("match", matched, ac[i].hit);
      chk("stretch", scl_oe, ac[i].hit);
      if (ac[i].hit) begin
        rdy_e <= 1'b1;
        for (n = 0; n < 400 && go_seen !== 1'b1; n++) @(posedge clk_i);
        if (n == 400) begin
          miscompares++;
          report_and_stop();
        end
        // setup minus one ticks, plus load, tick phase and catcher delay
        n = (ac[i].su - 1) * D;
        chk("setup", gocnt >= n - D + 3 && gocnt <= n + 2, 1'b1);
        rdy_e <= 1'b0;
      end
      master.stop();
    end
    $display("test address done");
    // forced stop: both lines pulled, then released with a stop condition
    apb(1'b1, 8'h00, 32'h0000_8000);
    stp = 1'b0; both = 1'b0; prev = sda_w;
    repeat (40*D) begin
      @(posedge clk_i);
      if (sda_w && !prev && scl_w) stp = 1'b1;
      if (sda_oe && scl_oe) both = 1'b1;
      prev = sda_w;
    end
    chk("fs_both", both, 1'b1);
    chk("fs_stop", stp, 1'b1);
    chk("fs_rel", {scl_oe, sda_oe}, 2'b00);
    apb(1'b1, 8'h00, 0);
    $display("test force stop done");
    // second reset restores defaults
    apb(1'b1, 8'h04, 32'h0001_0001);
    do_reset();
    apb(1'b0, 8'h04, 0);
    chk("scfg_rst", rd, 32'h000F_0055);
    apb(1'b0, 8'h00, 0);
    chk("ctrl_rst", rd, 32'h0000_0000);
    chk("fault", fault, 1'b0);
    $display("test reset done");
    report_and_stop();
  end
endmodule // i2c_filter_slave_address_config_bench
`default_nettype wire

// ---- verification/i2cf_bus_master.sv ----
`timescale 1ns/10ps
`default_nettype none
module i2cf_bus_master #(
  parameter int HB = 16
) (
  input  wire logic clk_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_lo_o,
  output logic      sda_lo_o,
  output logic      fault_o
);
  initial begin
    scl_lo_o = 1'b0;
    sda_lo_o = 1'b0;
    fault_o  = 1'b0;
  end
  // half a bit period of bus time
  task automatic half();
    repeat (HB) @(posedge clk_i);
  endtask
  // let scl go and wait out any stretching, bounded
  task automatic rise();
    int n;
    @(posedge clk_i) scl_lo_o <= 1'b0;
    for (n = 0; n < 2000 && scl_i !== 1'b1; n++) @(posedge clk_i);
    if (n == 2000) fault_o <= 1'b1;
  endtask
  // start: data falls while clock is high
  task automatic start();
    @(posedge clk_i) sda_lo_o <= 1'b1;
    half();
    @(posedge clk_i) scl_lo_o <= 1'b1;
    half();
  endtask
  // eight data bits msb first, then the acknowledge clock
  task automatic xbyte(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      @(posedge clk_i) sda_lo_o <= (i == 0) ? 1'b0 : ~b[i-1];
      half();
      rise();
      if (i == 0) ack = ~sda_i;
      half();
      @(posedge clk_i) scl_lo_o <= 1'b1;
    end
  endtask
  // stop: data rises while clock is high
  task automatic stop();
    @(posedge clk_i) sda_lo_o <= 1'b1;
    half();
    rise();
    half();
    @(posedge clk_i) sda_lo_o <= 1'b0;
    half();
  endtask
  // pull data low for n clocks while the bus is idle
  task automatic spike(input int n);
    @(posedge clk_i) sda_lo_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    sda_lo_o <= 1'b0;
  endtask
endmodule // i2cf_bus_master
`default_nettype wire
